// >>> src/bpci_top.sv
// The address map and the APB interface to the registers were left to the implementer.
`include "bpci_map.svh"

module bpci_top
   import bpci_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        osc_tick,
   input  wire bpci_cmp_t   cmp,
   input  wire logic        discharge_switch_en,
   input  wire logic        charge_switch_en,
   input  wire logic        power_off,
   output bpci_param_t      applied,
   output logic [4:0]       prot_trip,
   output logic             irq,
   output logic             irq_wake
);

   // Register file
   logic [5:0]  ctrl;
   logic [6:0]  sct;
   logic [5:0]  oct;
   logic [5:0]  hct;
   logic [7:0]  scl;
   logic [5:0]  ien;
   logic [5:0]  iflg;
   bpci_guard_t gstate;
   logic [1:0]  gcnt;
   bpci_lock_t  lstate;
   logic [2:0]  lcnt;
   logic        lock_enable_bit;
   logic        busy;
   logic        wr;
   logic        rd_setup;
   logic        param_wr;
   logic        param_ok;
   logic [5:0]  flag_set;
   logic        dsw_q;
   logic        csw_q;

   function automatic logic is_param(input logic [7:0] a);
      is_param = (a == `BPCI_OFS_CTRL) || (a == `BPCI_OFS_SCT) || (a == `BPCI_OFS_OCT)
              || (a == `BPCI_OFS_HCT) || (a == `BPCI_OFS_SCL);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = is_param(a) || (a == `BPCI_OFS_LOCK) || (a == `BPCI_OFS_IEN)
               || (a == `BPCI_OFS_IFLG);
   endfunction

   // Reaction time in oscillator ticks for protection index
   function automatic logic [14:0] react_ticks(input int idx, input bpci_param_t p);
      logic [6:0] n;
      n = 7'h00;
      react_ticks = 15'h0000;
      case (idx)
         4:
         begin
            n = (p.short_circuit_delay_field < 7'h02) ? 7'h01 : p.short_circuit_delay_field;
            react_ticks = 15'(n * `BPCI_SC_STEP_TICKS + `BPCI_SC_OFS_TICKS);
         end
         3, 2:
         begin
            n = {1'b0, (p.overcurrent_delay_field < 6'h02) ? 6'h01 : p.overcurrent_delay_field};
            react_ticks = 15'(n * `BPCI_OC_STEP_TICKS);
         end
         default:
         begin
            n = {1'b0, (p.highcurrent_delay_field < 6'h02) ? 6'h01 : p.highcurrent_delay_field};
            react_ticks = 15'(n * `BPCI_HC_STEP_TICKS);
         end
      endcase
   endfunction

   function automatic logic [4:0] reinit_ticks(input int idx);
      case (idx)
         4:       reinit_ticks = 5'(`BPCI_SC_REINIT_TICKS);
         3, 2:    reinit_ticks = 5'(`BPCI_OC_REINIT_TICKS);
         default: reinit_ticks = 5'(`BPCI_HC_REINIT_TICKS);
      endcase
   endfunction

   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign busy     = (gstate != BPCI_G_IDLE);
   assign param_ok = !busy && (lstate != BPCI_L_LOCKED);
   assign param_wr = wr && is_param(paddr) && param_ok;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !is_mapped(paddr);

   // Parameter registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= `BPCI_CTRL_RST;
         sct  <= `BPCI_SCT_RST;
         oct  <= `BPCI_OCT_RST;
         hct  <= `BPCI_HCT_RST;
         scl  <= `BPCI_SCL_RST;
      end
      else if (param_wr)
      begin
         case (paddr)
            `BPCI_OFS_CTRL: ctrl <= pwdata[5:0];
            `BPCI_OFS_SCT:  sct  <= pwdata[6:0];
            `BPCI_OFS_OCT:  oct  <= pwdata[5:0];
            `BPCI_OFS_HCT:  hct  <= pwdata[5:0];
            `BPCI_OFS_SCL:  scl  <= pwdata[7:0];
            default:        ctrl <= ctrl;
         endcase
      end
   end

   // Write guard: oscillator ticks, then CPU cycles, then apply
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gstate <= BPCI_G_IDLE;
         gcnt   <= 2'h0;
      end
      else
      begin
         case (gstate)
            BPCI_G_IDLE:
               if (param_wr)
               begin
                  gstate <= BPCI_G_OSC;
                  gcnt   <= 2'h0;
               end
            BPCI_G_OSC:
               if (osc_tick)
               begin
                  if (gcnt == 2'(`BPCI_GUARD_OSC - 1))
                  begin
                     gstate <= BPCI_G_CPU;
                     gcnt   <= 2'h0;
                  end
                  else
                     gcnt <= gcnt + 2'h1;
               end
            BPCI_G_CPU:
               if (gcnt == 2'(`BPCI_GUARD_CPU - 1))
                  gstate <= BPCI_G_IDLE;
               else
                  gcnt <= gcnt + 2'h1;
            default:
               gstate <= BPCI_G_IDLE;
         endcase
      end
   end

   // Protection unit sees new values only at the end of the guard
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         applied <= '{`BPCI_CTRL_RST, `BPCI_SCT_RST, `BPCI_OCT_RST, `BPCI_HCT_RST,
                      `BPCI_SCL_RST};
      else if (gstate == BPCI_G_CPU && gcnt == 2'(`BPCI_GUARD_CPU - 1))
         applied <= '{ctrl, sct, oct, hct, scl};
   end

   // Lock sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lstate          <= BPCI_L_OPEN;
         lcnt            <= 3'h0;
         lock_enable_bit <= 1'b0;
      end
      else
      begin
         case (lstate)
            BPCI_L_OPEN:
               if (wr && paddr == `BPCI_OFS_LOCK && pwdata[1:0] == 2'h3)
               begin
                  lstate          <= BPCI_L_ARMED;
                  lcnt            <= 3'h0;
                  lock_enable_bit <= 1'b1;
               end
            BPCI_L_ARMED:
               if (wr && paddr == `BPCI_OFS_LOCK && pwdata[1:0] == 2'h1)
               begin
                  lstate          <= BPCI_L_LOCKED;
                  lock_enable_bit <= 1'b0;
               end
               else if (wr && paddr == `BPCI_OFS_LOCK && pwdata[1:0] == 2'h3)
                  lcnt <= 3'h0;
               else if (lcnt == 3'(`BPCI_LOCK_WINDOW - 1) || (wr && paddr == `BPCI_OFS_LOCK))
               begin
                  lstate          <= BPCI_L_OPEN;
                  lock_enable_bit <= 1'b0;
               end
               else
                  lcnt <= lcnt + 3'h1;
            BPCI_L_LOCKED:
               lstate <= BPCI_L_LOCKED;
            default:
               lstate <= BPCI_L_OPEN;
         endcase
      end
   end

   // Interrupt enables and flags
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ien <= `BPCI_IEN_RST;
      else if (wr && paddr == `BPCI_OFS_IEN)
         ien <= pwdata[5:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         iflg <= 6'h00;
      else if (wr && paddr == `BPCI_OFS_IFLG)
         iflg <= (iflg & pwdata[5:0]) | flag_set;
      else
         iflg <= iflg | flag_set;
   end

   assign flag_set[`BPCI_UV_BIT] = cmp.uv_warn && applied.disable_n[`BPCI_UV_BIT];
   assign flag_set[4:0]          = prot_trip;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(iflg & ien);
   end

   assign irq_wake = irq && !power_off;

   // Switch history for restart detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dsw_q <= 1'b0;
         csw_q <= 1'b0;
      end
      else
      begin
         dsw_q <= discharge_switch_en;
         csw_q <= charge_switch_en;
      end
   end

   // Current protections, index equals flag bit
   for (genvar i = 0; i < 5; i++)
   begin : g_prot
      logic [14:0] run;
      logic [4:0]  hold;
      logic        fired;
      logic        level;
      logic        sw;
      logic        sw_rise;

      assign level   = cmp[i];
      assign sw      = (i == 4 || i == 3 || i == 1) ? discharge_switch_en : charge_switch_en;
      assign sw_rise = sw && !((i == 4 || i == 3 || i == 1) ? dsw_q : csw_q);

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            run       <= 15'h0000;
            hold      <= 5'h00;
            fired     <= 1'b0;
            prot_trip[i] <= 1'b0;
         end
         else
         begin
            prot_trip[i] <= 1'b0;
            if (sw_rise)
            begin
               hold <= reinit_ticks(i);
               run  <= 15'h0000;
            end
            else if (!sw || !applied.disable_n[i] || !level)
            begin
               run   <= 15'h0000;
               fired <= 1'b0;
            end
            else if (osc_tick)
            begin
               if (hold != 5'h00)
                  hold <= hold - 5'h01;
               else if (!fired && run >= react_ticks(i, applied))
               begin
                  fired        <= 1'b1;
                  prot_trip[i] <= 1'b1;
               end
               else if (!fired)
                  run <= run + 15'h0001;
            end
         end
      end
   end

   // Read data, captured in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         case (paddr)
            `BPCI_OFS_LOCK: prdata <= {29'h0, busy, lock_enable_bit,
                                       lstate == BPCI_L_LOCKED};
            `BPCI_OFS_CTRL: prdata <= {26'h0, ctrl};
            `BPCI_OFS_SCT:  prdata <= {25'h0, sct};
            `BPCI_OFS_OCT:  prdata <= {26'h0, oct};
            `BPCI_OFS_HCT:  prdata <= {26'h0, hct};
            `BPCI_OFS_SCL:  prdata <= {24'h0, scl};
            `BPCI_OFS_IEN:  prdata <= {26'h0, ien};
            `BPCI_OFS_IFLG: prdata <= {26'h0, iflg};
            default:        prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

// >>> src/bpci_map.svh
`ifndef BPCI_MAP_SVH
`define BPCI_MAP_SVH

// Register byte offsets
`define BPCI_OFS_LOCK         8'h00
`define BPCI_OFS_CTRL         8'h04
`define BPCI_OFS_SCT          8'h08
`define BPCI_OFS_OCT          8'h0C
`define BPCI_OFS_HCT          8'h10
`define BPCI_OFS_SCL          8'h14
`define BPCI_OFS_IEN          8'h18
`define BPCI_OFS_IFLG         8'h1C

// Lock register fields
`define BPCI_LOCK_BIT         0
`define BPCI_LOCK_EN_BIT      1
`define BPCI_BUSY_BIT         2

// Flag, enable and control bit positions
`define BPCI_UV_BIT           5
`define BPCI_SC_BIT           4

// Reset values
`define BPCI_CTRL_RST         6'h3F
`define BPCI_SCT_RST          7'h10
`define BPCI_OCT_RST          6'h00
`define BPCI_HCT_RST          6'h00
`define BPCI_SCL_RST          8'h00
`define BPCI_IEN_RST          6'h00

// Timing
`define BPCI_PCLK_NS          100
`define BPCI_OSC_NS           7812
`define BPCI_SC_STEP_NS       78120
`define BPCI_SC_OFS_NS        7812
`define BPCI_OC_STEP_NS       625000
`define BPCI_HC_STEP_NS       2500000
`define BPCI_SC_REINIT_NS     86000
`define BPCI_OC_REINIT_NS     100000
`define BPCI_HC_REINIT_NS     200000
`define BPCI_SC_STEP_TICKS    (`BPCI_SC_STEP_NS / `BPCI_OSC_NS)
`define BPCI_SC_OFS_TICKS     (`BPCI_SC_OFS_NS / `BPCI_OSC_NS)
`define BPCI_OC_STEP_TICKS    (`BPCI_OC_STEP_NS / `BPCI_OSC_NS)
`define BPCI_HC_STEP_TICKS    (`BPCI_HC_STEP_NS / `BPCI_OSC_NS)
`define BPCI_SC_REINIT_TICKS  (`BPCI_SC_REINIT_NS / `BPCI_OSC_NS)
`define BPCI_OC_REINIT_TICKS  (`BPCI_OC_REINIT_NS / `BPCI_OSC_NS)
`define BPCI_HC_REINIT_TICKS  (`BPCI_HC_REINIT_NS / `BPCI_OSC_NS)
`define BPCI_GUARD_OSC        3
`define BPCI_GUARD_CPU        3
`define BPCI_LOCK_WINDOW      4

`endif

// >>> src/bpci_pkg.sv
package bpci_pkg;

   // Comparator outputs, one per condition, bit order as the flag register
   typedef struct packed {
      logic uv_warn;
      logic sc;
      logic doc;
      logic coc;
      logic dhc;
      logic chc;
   } bpci_cmp_t;

   // Parameters as applied inside the protection unit
   typedef struct packed {
      logic [5:0] disable_n;
      logic [6:0] short_circuit_delay_field;
      logic [5:0] overcurrent_delay_field;
      logic [5:0] highcurrent_delay_field;
      logic [7:0] short_circuit_threshold_field;
   } bpci_param_t;

   typedef enum logic [1:0] {
      BPCI_G_IDLE,
      BPCI_G_OSC,
      BPCI_G_CPU
   } bpci_guard_t;

   typedef enum logic [1:0] {
      BPCI_L_OPEN,
      BPCI_L_ARMED,
      BPCI_L_LOCKED
   } bpci_lock_t;

endpackage

// >>> tb/bpci_top_properties.sv
`include "bpci_map.svh"

module bpci_top_properties
   import bpci_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        osc_tick,
   input wire bpci_cmp_t   cmp,
   input wire logic        discharge_switch_en,
   input wire logic        power_off,
   input wire bpci_param_t applied,
   input wire logic [4:0]  prot_trip,
   input wire logic        irq,
   input wire logic        irq_wake
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire        wr_acc = psel && penable && pwrite;
   wire        rd_acc = psel && penable && !pwrite;
   wire        par_wr = wr_acc && paddr >= `BPCI_OFS_CTRL && paddr <= `BPCI_OFS_SCL;
   logic [7:0] sc_ticks;

   // Oscillator ticks seen with the short-circuit condition present
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sc_ticks <= 8'h00;
      else if (!(cmp.sc && discharge_switch_en))
         sc_ticks <= 8'h00;
      else if (osc_tick && sc_ticks != 8'hFF)
         sc_ticks <= sc_ticks + 8'h01;

   a_wake_gate:
   assert property (irq_wake == (irq && !power_off)) else $error("wake not gated");
   a_enable_gate:
   assert property (wr_acc && paddr == `BPCI_OFS_IEN && pwdata[5:0] == 6'h00
      |-> ##[1:2] !irq) else $error("irq with all enables off");
   a_flag_clear:
   assert property (wr_acc && paddr == `BPCI_OFS_IFLG && pwdata[5:0] == 6'h00
      && cmp == 6'h00 && prot_trip == 5'h00 |-> ##[1:2] !irq) else $error("flags kept");
   a_disable_gate:
   assert property ((prot_trip & ~$past(applied.disable_n[4:0])) == 5'h00)
      else $error("disabled protection tripped");
   a_sc_reaction:
   assert property (prot_trip[4] |-> sc_ticks >= 8'h0C) else $error("short trip early");
   a_sc_blank:
   assert property ($rose(discharge_switch_en) |-> !prot_trip[4] [*8])
      else $error("short trip right after switch on");
   a_lock_resv:
   assert property (rd_acc && paddr == `BPCI_OFS_LOCK |-> prdata[31:3] == 29'h0)
      else $error("lock reserved bits set");
   a_timing_resv:
   assert property (rd_acc && paddr == `BPCI_OFS_SCT |-> prdata[31:7] == 25'h0)
      else $error("timing reserved bit set");
   a_reset_vals:
   assert property ($rose(presetn) |-> applied.short_circuit_delay_field == 7'h10
      && applied.disable_n == 6'h3F) else $error("applied reset value");
   a_param_hold:
   assert property (par_wr |=> $stable(applied)) else $error("parameter applied at once");

   c_trip: cover property (prot_trip[4]);
   c_locked: cover property (rd_acc && paddr == `BPCI_OFS_LOCK && prdata[0]);
   c_wake: cover property (irq_wake);
endmodule

bind bpci_top bpci_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .osc_tick, .cmp, .discharge_switch_en, .power_off,
   .applied, .prot_trip, .irq, .irq_wake);

// >>> tb/bpci_cpu_model.sv
module bpci_cpu_model (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // Called just after a rising edge; returns just after one
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

// >>> tb/bpci_top_tb.sv
`include "bpci_map.svh"

module bpci_top_tb
   import bpci_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0] RV [8] = '{8'h00, 8'h3F, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        osc_tick = 1'b0;
   logic [1:0]  div = 2'h0;
   bpci_cmp_t   cmp;
   logic        discharge_switch_en, charge_switch_en, power_off, irq, irq_wake;
   bpci_param_t applied;
   logic [4:0]  prot_trip;
   int          fail_count = 0;
   int          checks = 0;

   bpci_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .osc_tick, .cmp, .discharge_switch_en, .charge_switch_en,
      .power_off, .applied, .prot_trip, .irq, .irq_wake);
   bpci_cpu_model i_cpu (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata);

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Protection oscillator tick every fourth CPU cycle
   always @(posedge pclk)
   begin
      div <= div + 2'h1;
      osc_tick <= (div == 2'h3);
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_cpu.xfer(a, 1'b1, v, q, e);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      i_cpu.xfer(a, 1'b0, 32'h0, q, e);
      chk(q, x);
   endtask

   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      i_cpu.xfer(a, 1'b0, 32'h0, q, e);
      for (int n = 0; n < 100 && (q & m) !== x; n++)
         i_cpu.xfer(a, 1'b0, 32'h0, q, e);
      chk(q & m, x);
   endtask

   task finish_test;
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #1000000;
      fail_count++;
      finish_test;
   end

   initial
   begin
      presetn = 1'b0;
      cmp = 6'h00;
      discharge_switch_en = 1'b0;
      charge_switch_en = 1'b1;
      power_off = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++)
         rc(8'(i * 4), {24'h0, RV[i]});
      i_cpu.xfer(8'h20, 1'b0, 32'h0, q, e);
      chk(32'(e), 32'h1);
      // Second write lands inside the guard of the first
      wr(`BPCI_OFS_SCT, 32'hFF);
      wr(`BPCI_OFS_OCT, 32'h3F);
      rc(`BPCI_OFS_LOCK, 32'h4);
      chk(32'(applied.short_circuit_delay_field), 32'h10);
      poll(`BPCI_OFS_LOCK, 32'h4, 32'h0);
      rc(`BPCI_OFS_SCT, 32'h7F);
      rc(`BPCI_OFS_OCT, 32'h0);
      chk(32'(applied.short_circuit_delay_field), 32'h7F);
      wr(`BPCI_OFS_SCT, 32'h1);
      poll(`BPCI_OFS_LOCK, 32'h4, 32'h0);
      wr(`BPCI_OFS_IEN, 32'h10);
      cmp <= 6'h10;
      discharge_switch_en <= 1'b1;
      poll(`BPCI_OFS_IFLG, 32'h10, 32'h10);
      chk(32'(irq), 32'h1);
      chk(32'(irq_wake), 32'h1);
      power_off <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'(irq_wake), 32'h0);
      wr(`BPCI_OFS_IEN, 32'h0);
      @(posedge pclk);
      chk(32'(irq), 32'h0);
      wr(`BPCI_OFS_IEN, 32'hFF);
      rc(`BPCI_OFS_IEN, 32'h3F);
      wr(`BPCI_OFS_IEN, 32'h10);
      power_off <= 1'b0;
      cmp <= 6'h00;
      repeat (2) @(posedge pclk);
      wr(`BPCI_OFS_IFLG, 32'h3F);
      rc(`BPCI_OFS_IFLG, 32'h10);
      wr(`BPCI_OFS_IFLG, 32'h2F);
      rc(`BPCI_OFS_IFLG, 32'h0);
      chk(32'(irq), 32'h0);
      cmp <= 6'h20;
      @(posedge pclk);
      cmp <= 6'h00;
      rc(`BPCI_OFS_IFLG, 32'h20);
      chk(32'(irq), 32'h0);
      wr(`BPCI_OFS_IFLG, 32'h0);
      wr(`BPCI_OFS_CTRL, 32'h2F);
      poll(`BPCI_OFS_LOCK, 32'h4, 32'h0);
      cmp <= 6'h10;
      repeat (150) @(posedge pclk);
      cmp <= 6'h00;
      rc(`BPCI_OFS_IFLG, 32'h0);
      // Discharge over-current at code 0: 80 ticks must pass before the trip
      cmp <= 6'h08;
      repeat (300) @(posedge pclk);
      rc(`BPCI_OFS_IFLG, 32'h0);
      repeat (100) @(posedge pclk);
      cmp <= 6'h00;
      rc(`BPCI_OFS_IFLG, 32'h08);
      wr(`BPCI_OFS_IFLG, 32'h0);
      wr(`BPCI_OFS_SCL, 32'hA5);
      poll(`BPCI_OFS_LOCK, 32'h4, 32'h0);
      rc(`BPCI_OFS_SCL, 32'hA5);
      chk(32'(applied.short_circuit_threshold_field), 32'hA5);
      wr(`BPCI_OFS_LOCK, 32'h3);
      rc(`BPCI_OFS_LOCK, 32'h2);
      repeat (6) @(posedge pclk);
      rc(`BPCI_OFS_LOCK, 32'h0);
      wr(`BPCI_OFS_LOCK, 32'h1);
      rc(`BPCI_OFS_LOCK, 32'h0);
      wr(`BPCI_OFS_LOCK, 32'h3);
      wr(`BPCI_OFS_LOCK, 32'h1);
      rc(`BPCI_OFS_LOCK, 32'h1);
      wr(`BPCI_OFS_SCL, 32'h77);
      repeat (40) @(posedge pclk);
      rc(`BPCI_OFS_SCL, 32'hA5);
      chk(32'(applied.short_circuit_threshold_field), 32'hA5);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(`BPCI_OFS_LOCK, 32'h0);
      rc(`BPCI_OFS_SCL, 32'h0);
      finish_test;
   end
endmodule
